// *** verilog/machine_cycle_sequencer.v ***
// machine cycle sequencer: state ring, instruction length, external move timing, reset sampling
// Function
// - every machine cycle lasts exactly four clock periods, one state each
// - states run C1, C2, C3, C4, then C1 again
// - both clock edges give timing events inside each state
// - one opcode fetch is issued per machine cycle, except while internal reset is held
// - half the opcodes, 128 of 256, finish in one machine cycle
// - two-byte and some one-byte opcodes take two machine cycles
// - remaining instructions take three, four or five machine cycles
// - external data move stretches from two to nine machine cycles
// - read and write strobes widen with the stretch; partner finishes inside
// - indirect form: low from working register, high from port 2; pointer form: 16 bits
// - selector bit zero picks first or second data pointer; other bits zero
// - reset pin sampled in C4; internal reset after two high samples
// - reset held two cycles after pin drops, then fetch from 0000h
`timescale 1ns/1ps
`default_nettype none
`include "cycle_seq_defs.vh"

module machine_cycle_sequencer (
    // clock and reset
    input wire clk,
    input wire reset,
    // external reset pin
    input wire reset_pin,
    // instruction from the decoder
    input wire instr_start,
    input wire [2:0] instr_cycles,
    input wire external_data_move,
    input wire move_is_write,
    input wire move_is_indirect,
    input wire [2:0] stretch,
    // address sources
    input wire [7:0] indirect_working_register,
    input wire [7:0] port2_latch,
    input wire [15:0] data_pointer_first,
    input wire [15:0] data_pointer_second,
    input wire [7:0] pointer_select,
    // state outputs
    output reg [3:0] state_onehot,
    output reg cycle_boundary,
    output reg fetch_strobe,
    output reg half_state,
    output reg instr_done,
    output reg core_reset,
    output reg [15:0] fetch_addr_reset,
    // external memory side
    output reg [15:0] ext_addr,
    output reg read_strobe_n,
    output reg write_strobe_n,
    output reg [7:0] pointer_select_read
);

    localparam [3:0] ST_C1 = 4'b0001;
    localparam [3:0] ST_C2 = 4'b0010;
    localparam [3:0] ST_C3 = 4'b0100;
    localparam [3:0] ST_C4 = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [2:0] pin_sync;
    reg pin_level;
    reg [1:0] high_count;
    reg [1:0] hold_count;
    reg in_reset;
    reg [3:0] cycles_left;
    reg busy;
    reg move_active;
    reg move_write;
    reg neg_phase;
    reg pos_phase;
    wire [3:0] move_len;
    wire [3:0] instr_len;
    wire last_state;
    wire end_of_instr;

    assign last_state = (state == ST_C4);
    // stretch 0..7 maps to 2..9 machine cycles
    assign move_len = `XMOVE_MIN_CYCLES + {1'b0, stretch};
    // out-of-range lengths clamp into the five classes
    assign instr_len = (instr_cycles < `MIN_LEN_CYCLES) ? {1'b0, `MIN_LEN_CYCLES} :
                       (instr_cycles > `MAX_LEN_CYCLES) ? {1'b0, `MAX_LEN_CYCLES} :
                       {1'b0, instr_cycles};
    assign end_of_instr = busy && last_state && (cycles_left == 4'h1);

    // state ring advances one step every clock
    always @* begin
        case (state)
            ST_C1: next_state = ST_C2;
            ST_C2: next_state = ST_C3;
            ST_C3: next_state = ST_C4;
            ST_C4: next_state = ST_C1;
            default: next_state = ST_C1;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state <= ST_C1;
        end else begin
            state <= next_state;
        end
    end

    // falling-edge phase marker; follows the inverse of the rising-edge copy, so it needs no reset
    // of its own and never samples the reset line on the edge where that line is allowed to move
    always @(negedge clk) begin
        neg_phase <= ~pos_phase;
    end

    always @(posedge clk) begin
        if (reset) begin
            pos_phase <= 1'b0;
            half_state <= 1'b0;
        end else begin
            pos_phase <= neg_phase;
            // high when a falling edge occurred inside the past state
            half_state <= neg_phase ^ pos_phase;
        end
    end

    // pin synchroniser; only the agreed level of stages two and three is used
    always @(posedge clk) begin
        if (reset) begin
            pin_sync <= 3'h0;
            pin_level <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], reset_pin};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= pin_sync[2];
            end
        end
    end

    // pin sampled once per machine cycle in C4, entry and exit filtered by counts
    always @(posedge clk) begin
        if (reset) begin
            high_count <= 2'h0;
            hold_count <= 2'h0;
            in_reset <= 1'b0;
        end else if (last_state) begin
            if (pin_level) begin
                hold_count <= 2'h0;
                if (high_count != `RESET_SEEN_CYCLES) begin
                    high_count <= high_count + 2'h1;
                end
                if (high_count + 2'h1 >= `RESET_SEEN_CYCLES) begin
                    in_reset <= 1'b1;
                end
            end else begin
                high_count <= 2'h0;
                if (in_reset) begin
                    // hold on after release before fetching resumes
                    if (hold_count + 2'h1 >= `RESET_HOLD_CYCLES) begin
                        in_reset <= 1'b0;
                        hold_count <= 2'h0;
                    end else begin
                        hold_count <= hold_count + 2'h1;
                    end
                end
            end
        end
    end

    // instruction length tracking; a new instruction is taken only at a cycle boundary
    always @(posedge clk) begin
        if (reset || in_reset) begin
            busy <= 1'b0;
            cycles_left <= 4'h0;
            move_active <= 1'b0;
            move_write <= 1'b0;
            ext_addr <= 16'h0000;
        end else if (last_state && (!busy || end_of_instr)) begin
            busy <= instr_start;
            move_active <= instr_start && external_data_move;
            move_write <= move_is_write;
            if (external_data_move) begin
                cycles_left <= move_len;
            end else begin
                cycles_left <= instr_len;
            end
            if (move_is_indirect) begin
                ext_addr <= {port2_latch, indirect_working_register};
            end else if (pointer_select[`SELECTOR_BIT]) begin
                ext_addr <= data_pointer_second;
            end else begin
                ext_addr <= data_pointer_first;
            end
        end else if (busy && last_state) begin
            cycles_left <= cycles_left - 4'h1;
        end
    end

    // registered outputs; strobes span every cycle of the move except the last
    always @(posedge clk) begin
        if (reset) begin
            state_onehot <= ST_C1;
            cycle_boundary <= 1'b0;
            fetch_strobe <= 1'b0;
            instr_done <= 1'b0;
            core_reset <= 1'b1;
            fetch_addr_reset <= `RESET_VECTOR;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            pointer_select_read <= 8'h00;
        end else begin
            state_onehot <= next_state;
            cycle_boundary <= (next_state == ST_C1);
            fetch_strobe <= (next_state == ST_C1) && !in_reset;
            instr_done <= end_of_instr;
            core_reset <= in_reset;
            fetch_addr_reset <= `RESET_VECTOR;
            // strobe widened with the stretch; the partner must finish before it ends
            read_strobe_n <= ~(move_active && busy && !move_write && cycles_left != move_len_hold(cycles_left));
            write_strobe_n <= ~(move_active && busy && move_write && cycles_left != move_len_hold(cycles_left));
            pointer_select_read <= {7'h00, pointer_select[`SELECTOR_BIT]};
        end
    end

    // strobe covers all cycles except the last one, which returns the bus
    function [3:0] move_len_hold;
        input [3:0] left;
        begin
            move_len_hold = (left <= 4'h1) ? left : 4'hF;
        end
    endfunction

endmodule // machine_cycle_sequencer
`default_nettype wire

// *** verilog/cycle_seq_defs.vh ***
// constants for the machine cycle sequencer
`ifndef CYCLE_SEQ_DEFS_VH
`define CYCLE_SEQ_DEFS_VH
`define STATES_PER_CYCLE 3'h4
`define MIN_LEN_CYCLES 3'h1
`define MAX_LEN_CYCLES 3'h5
`define XMOVE_MIN_CYCLES 4'h2
`define XMOVE_MAX_CYCLES 4'h9
`define RESET_SEEN_CYCLES 2'h2
`define RESET_HOLD_CYCLES 2'h2
`define RESET_VECTOR 16'h0000
`define SELECTOR_ADDR 8'h86
`define SELECTOR_BIT 0
`define SYNC_STAGES 3
`endif

// *** tb/machine_cycle_sequencer_props.sv ***
// assertions on the sequencer state ring, strobes and pulses
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_sequencer_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched outputs
    input wire logic [3:0] state_onehot,
    input wire logic cycle_boundary,
    input wire logic fetch_strobe,
    input wire logic instr_done,
    input wire logic core_reset,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ring_step: assert property (state_onehot inside {4'h1, 4'h2, 4'h4} |=> state_onehot == $past(state_onehot) << 1)
        else $error("state ring skipped");
    a_ring_wrap: assert property (state_onehot == 4'h8 |=> state_onehot == 4'h1)
        else $error("ring did not wrap");
    a_cycle_length: assert property (cycle_boundary |=> !cycle_boundary [*3] ##1 cycle_boundary)
        else $error("machine cycle not four clocks");
    a_boundary_in_c1: assert property (cycle_boundary |-> state_onehot == 4'h1)
        else $error("boundary outside first state");
    a_fetch_in_c1: assert property (fetch_strobe |-> state_onehot == 4'h1)
        else $error("fetch outside first state");
    a_fetch_each_cycle: assert property (cycle_boundary && !core_reset && !$past(core_reset) |-> fetch_strobe)
        else $error("machine cycle without fetch");
    a_strobe_exclusive: assert property (!read_strobe_n |-> write_strobe_n)
        else $error("both strobes low");
    a_strobe_edge: assert property ($changed(read_strobe_n) || $changed(write_strobe_n) |-> state_onehot == 4'h2)
        else $error("strobe moved outside the second state");
    a_done_in_c1: assert property (instr_done |-> state_onehot == 4'h1)
        else $error("done outside first state");
    c_done: cover property (instr_done);
    c_write: cover property (!write_strobe_n);
    c_core_reset: cover property ($rose(core_reset));
endmodule // machine_cycle_sequencer_props
bind machine_cycle_sequencer machine_cycle_sequencer_props machine_cycle_sequencer_props_inst (.clk(clk), .reset(reset),
    .state_onehot(state_onehot), .cycle_boundary(cycle_boundary), .fetch_strobe(fetch_strobe), .instr_done(instr_done),
    .core_reset(core_reset), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
`default_nettype wire

// *** tb/ext_mem_model.sv ***
// external memory that completes an access only inside a long enough strobe
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(parameter int ACCESS_CLKS = 12) (
    // clock and strobes
    input wire logic clk,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    // accesses finished
    output logic [7:0] done_count
);
    int run = 0;
    initial done_count = 8'h00;
    // a slow part latches only after the strobe has stood ACCESS_CLKS clocks
    always @(posedge clk) begin
        run <= (!read_strobe_n || !write_strobe_n) ? run + 1 : 0;
        if ((!read_strobe_n || !write_strobe_n) && run + 1 == ACCESS_CLKS) done_count <= done_count + 8'h01;
    end
endmodule // ext_mem_model
`default_nettype wire

// *** tb/test_machine_cycle_sequencer.sv ***
// self-checking bench for the machine cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module test_machine_cycle_sequencer;
    logic clk = 1'b0, reset = 1'b1, reset_pin = 1'b0, instr_start = 1'b0, external_data_move = 1'b0;
    logic move_is_write = 1'b0, move_is_indirect = 1'b0, wr = 1'b0;
    logic [2:0] instr_cycles = 3'h0, stretch = 3'h0;
    logic [7:0] indirect_working_register = 8'h00, port2_latch = 8'h00, pointer_select = 8'h00;
    logic [15:0] data_pointer_first = 16'h0000, data_pointer_second = 16'h0000, fetch_addr_reset, ext_addr;
    logic [3:0] state_onehot;
    logic cycle_boundary, fetch_strobe, half_state, instr_done, core_reset, read_strobe_n, write_strobe_n;
    logic [7:0] pointer_select_read, done_count;
    int cyc = 0, free_at = 0, n_errors = 0, tests_run = 0, run = 0, moves_ok = 0;
    int done_q[$];
    logic [22:0] st_q[$];
    machine_cycle_sequencer machine_cycle_sequencer_inst (.clk(clk), .reset(reset), .reset_pin(reset_pin),
        .instr_start(instr_start), .instr_cycles(instr_cycles), .external_data_move(external_data_move),
        .move_is_write(move_is_write), .move_is_indirect(move_is_indirect), .stretch(stretch),
        .indirect_working_register(indirect_working_register), .port2_latch(port2_latch),
        .data_pointer_first(data_pointer_first), .data_pointer_second(data_pointer_second),
        .pointer_select(pointer_select), .state_onehot(state_onehot), .cycle_boundary(cycle_boundary),
        .fetch_strobe(fetch_strobe), .half_state(half_state), .instr_done(instr_done), .core_reset(core_reset),
        .fetch_addr_reset(fetch_addr_reset), .ext_addr(ext_addr), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .pointer_select_read(pointer_select_read));
    ext_mem_model ext_mem_model_inst (.clk(clk), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .done_count(done_count));
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // request is held only for the C4 edge that takes it; expectations noted for the monitor
    task automatic issue(input logic [2:0] n, input logic mv, input logic [2:0] s);
        int len;
        do @(negedge clk); while (cyc + 1 < free_at || state_onehot !== 4'h8);
        {move_is_write, move_is_indirect, indirect_working_register, port2_latch, pointer_select} = $urandom;
        {data_pointer_first, data_pointer_second} = $urandom;
        {instr_start, instr_cycles, external_data_move, stretch} = {1'b1, n, mv, s};
        len = mv ? 2 + s : (n == 0 ? 1 : (n > 5 ? 5 : n));
        free_at = cyc + 1 + 4 * len;
        done_q.push_back(free_at);
        if (mv) st_q.push_back({move_is_write, 6'(4 * len - 4), move_is_indirect ? {port2_latch,
            indirect_working_register} : (pointer_select[0] ? data_pointer_second : data_pointer_first)});
        if (mv && 4 * len - 4 >= 12) moves_ok++;
        @(negedge clk) instr_start = 1'b0;
        chk(pointer_select_read, {7'h00, pointer_select[0]});
        {data_pointer_first, data_pointer_second, port2_latch} = $urandom; // address must stay as captured
    endtask
    // monitor: results taken in order against the oldest note
    always @(negedge clk) begin
        if (instr_done) chk(cyc, done_q.pop_front());
        if (!read_strobe_n || !write_strobe_n) begin
            run++;
            wr = !write_strobe_n;
        end else if (run > 0) begin
            chk({wr, 6'(run), ext_addr}, st_q.pop_front());
            run = 0;
        end
    end
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hAF5E8519));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int n = 0; n < 8; n++) issue(3'(n), 1'b0, 3'h0);
        for (int s = 0; s < 8; s++) issue(3'h1, 1'b1, 3'(s));
        chk(half_state, 1'b1);
        $display("lengths and moves done");
        // a request while busy is refused, so no extra done may appear
        issue(3'h5, 1'b0, 3'h0);
        repeat (7) @(negedge clk);
        instr_start = 1'b1;
        repeat (4) @(negedge clk);
        instr_start = 1'b0;
        repeat (30) @(negedge clk);
        chk(done_q.size() + st_q.size(), 0);
        $display("refusal done");
        // a pin pulse that falls between two C4 samples must not reset the core
        reset_pin = 1'b1;
        repeat (2) @(negedge clk);
        reset_pin = 1'b0;
        repeat (20) @(negedge clk);
        chk(core_reset, 1'b0);
        reset_pin = 1'b1;
        repeat (5) @(negedge clk);
        chk(core_reset, 1'b0);
        repeat (15) @(negedge clk);
        chk(core_reset, 1'b1);
        reset_pin = 1'b0;
        repeat (9) @(negedge clk);
        chk(core_reset, 1'b1);
        repeat (15) @(negedge clk);
        chk({core_reset, fetch_addr_reset}, 17'h00000);
        chk(done_count, moves_ok);
        $display("reset pin done");
        finish_test();
    end
endmodule // test_machine_cycle_sequencer
`default_nettype wire
